// ===== rtl/ssr_pkg.sv
// package: constants and carrier types for the two-wire port block
package ssr_pkg;
    // register addresses (word index on the plain port)
    localparam logic [3:0] ADDR_BUF    = 4'h0;
    localparam logic [3:0] ADDR_STATUS = 4'h1;
    localparam logic [3:0] ADDR_CTRL   = 4'h2;
    localparam logic [3:0] ADDR_BAUD   = 4'h3;
    localparam logic [3:0] ADDR_IRQST  = 4'h4;
    localparam logic [3:0] ADDR_IRQMSK = 4'h5;
    localparam logic [3:0] ADDR_CMD    = 4'h6;
    // field positions
    localparam int BF_BIT    = 0;
    localparam int OV_BIT    = 6;
    localparam int EN_BIT    = 5;
    localparam int CMD_START = 0;
    localparam int IRQ_PORT  = 0;
    localparam int IRQ_BCOL  = 1;
    localparam int BAUD_MSB  = 6;
    // reset values and the last bit index
    localparam logic [7:0] BAUD_RST = 8'h00;
    localparam logic [6:0] ADDR_RST = 7'h00;
    localparam logic [1:0] IRQ_RST  = 2'h0;
    localparam logic [2:0] BIT_LAST = 3'h7;
    // start generator states, gray coded along the usual path
    typedef enum logic [2:0] {
        SSR_IDLE  = 3'b000,
        SSR_CHECK = 3'b001,
        SSR_HOLD1 = 3'b011,
        SSR_HOLD2 = 3'b010,
        SSR_DONE  = 3'b110
    } ssr_start_t;
    // slave receive states
    typedef enum logic [1:0] {
        SSR_RX_IDLE = 2'b00,
        SSR_RX_BITS = 2'b01,
        SSR_RX_ACK  = 2'b11,
        SSR_RX_WAIT = 2'b10
    } ssr_rx_t;
    // filtered view of the bus lines
    typedef struct packed {
        logic scl;
        logic sda;
    } ssr_lines_t;
endpackage : ssr_pkg

// ===== rtl/ssr_port.sv
// two-wire port: slave receive with acknowledge and master start generation
`timescale 1ns/1ns
// Functional notes
// - as slave the block only receives and drives sda only for the ack.
// - after an address match or a matched data byte, store byte then ack.
// - no ack when buffer-full or overflow was already set before the byte.
// - byte with buffer full is not stored but still sets irq and overflow.
// - reading the buffer clears buffer-full; software clears overflow.
// - during start both lines are sampled in the check and the first count only.
// - a line already low at start aborts, flags collision, goes idle.
// - start releases lines; sda high loads the counter from baud 6:0.
// - scl low while sda high in the first count is a collision.
// - sda low in the first count resets the counter, sda driven early.
// - sda high through count: drive sda low, recount, then drive scl low.
// - scl low during the second count is not a collision.
// - two masters starting together are not a collision at start.
// - a full byte after an address match goes to the buffer if it is empty and sets the port irq flag.
// - in slave mode the baud register holds the slave address.
module ssr_port (
    input  wire logic       mclk_i,
    input  wire logic       reset_i,
    input  wire logic [3:0] addr_i,
    input  wire logic [7:0] wdata_i,
    input  wire logic       wr_i,
    input  wire logic       rd_i,
    output logic      [7:0] rdata_o,
    output logic            irq_o,
    input  wire logic       scl_i,
    input  wire logic       sda_i,
    output logic            scl_o,
    output logic            scl_oe_o,
    output logic            sda_o,
    output logic            sda_oe_o
);
    ////////////////////////////////////////////////////////////////////
    // input synchronisers: three stages, change taken when 1 and 2 agree
    logic [2:0]         scl_sy_reg;
    logic [2:0]         sda_sy_reg;
    ssr_pkg::ssr_lines_t ln_reg;
    ssr_pkg::ssr_lines_t ln_prev_reg;

    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            scl_sy_reg <= 3'h7;
            sda_sy_reg <= 3'h7;
        end else begin
            scl_sy_reg <= {scl_sy_reg[1:0], scl_i};
            sda_sy_reg <= {sda_sy_reg[1:0], sda_i};
        end
    end

    // filtered levels; stage 0 is read only by stage 1
    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            ln_reg      <= '{scl: 1'b1, sda: 1'b1};
            ln_prev_reg <= '{scl: 1'b1, sda: 1'b1};
        end else begin
            if (scl_sy_reg[1] == scl_sy_reg[2])
                ln_reg.scl <= scl_sy_reg[2];
            if (sda_sy_reg[1] == sda_sy_reg[2])
                ln_reg.sda <= sda_sy_reg[2];
            ln_prev_reg <= ln_reg;
        end
    end

    logic scl_rise;
    logic scl_fall;
    logic start_seen;
    logic stop_seen;
    assign scl_rise   = ln_reg.scl & ~ln_prev_reg.scl;
    assign scl_fall   = ~ln_reg.scl & ln_prev_reg.scl;
    assign start_seen = ln_reg.scl & ln_prev_reg.scl
                        & ln_prev_reg.sda & ~ln_reg.sda;
    assign stop_seen  = ln_reg.scl & ln_prev_reg.scl
                        & ~ln_prev_reg.sda & ln_reg.sda;

    ////////////////////////////////////////////////////////////////////
    // software registers
    logic [7:0] buf_reg;
    logic       bf_reg;
    logic       ov_reg;
    logic       en_reg;
    logic [7:0] baud_reg;
    logic [1:0] ist_reg;
    logic [1:0] imsk_reg;
    logic       byte_done;
    logic       bcol_evt;
    logic       wr_ctrl;
    logic       rd_buf;
    logic       go_start;
    assign wr_ctrl  = wr_i && addr_i == ssr_pkg::ADDR_CTRL;
    assign rd_buf   = rd_i && addr_i == ssr_pkg::ADDR_BUF;
    assign go_start = wr_i && addr_i == ssr_pkg::ADDR_CMD
                      && wdata_i[ssr_pkg::CMD_START];

    // control and baud/address registers
    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            en_reg   <= 1'b0;
            baud_reg <= ssr_pkg::BAUD_RST;
            imsk_reg <= ssr_pkg::IRQ_RST;
        end else begin
            if (wr_ctrl)
                en_reg <= wdata_i[ssr_pkg::EN_BIT];
            if (wr_i && addr_i == ssr_pkg::ADDR_BAUD)
                baud_reg <= wdata_i;
            if (wr_i && addr_i == ssr_pkg::ADDR_IRQMSK)
                imsk_reg <= wdata_i[1:0];
        end
    end

    // overflow: set by hardware wins over the software clear
    logic ov_set;
    logic bf_set;
    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            ov_reg <= 1'b0;
            bf_reg <= 1'b0;
        end else begin
            if (ov_set)
                ov_reg <= 1'b1;
            else if (wr_ctrl)
                ov_reg <= wdata_i[ssr_pkg::OV_BIT];
            if (bf_set)
                bf_reg <= 1'b1;
            else if (rd_buf)
                bf_reg <= 1'b0;
        end
    end

    // sticky status, write one to clear, new events win
    logic [1:0] ist_set;
    assign ist_set = {bcol_evt, byte_done};
    always_ff @(posedge mclk_i) begin
        if (reset_i)
            ist_reg <= ssr_pkg::IRQ_RST;
        else if (wr_i && addr_i == ssr_pkg::ADDR_IRQST)
            ist_reg <= (ist_reg & ~wdata_i[1:0]) | ist_set;
        else
            ist_reg <= ist_reg | ist_set;
    end

    always_ff @(posedge mclk_i) begin
        if (reset_i)
            irq_o <= 1'b0;
        else
            irq_o <= |(ist_reg & imsk_reg);
    end

    // read data one cycle after the strobe, zero otherwise
    always_ff @(posedge mclk_i) begin
        if (reset_i || !rd_i)
            rdata_o <= 8'h00;
        else begin
            unique case (addr_i)
                ssr_pkg::ADDR_BUF:    rdata_o <= buf_reg;
                ssr_pkg::ADDR_STATUS: rdata_o <= {7'h00, bf_reg};
                ssr_pkg::ADDR_CTRL:   rdata_o <= {1'b0, ov_reg, en_reg, 5'h00};
                ssr_pkg::ADDR_BAUD:   rdata_o <= baud_reg;
                ssr_pkg::ADDR_IRQST:  rdata_o <= {6'h00, ist_reg};
                ssr_pkg::ADDR_IRQMSK: rdata_o <= {6'h00, imsk_reg};
                default:              rdata_o <= 8'h00;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////
    // slave receiver
    ssr_pkg::ssr_rx_t rx_reg;
    logic [7:0] sr_reg;
    logic [2:0] bit_reg;
    logic       matched_reg;
    logic       ack_reg;
    logic       rx_sda_low;
    logic       full_byte;
    assign full_byte = rx_reg == ssr_pkg::SSR_RX_BITS && scl_rise
                       && bit_reg == ssr_pkg::BIT_LAST;
    assign ov_set    = full_byte && bf_reg
                       && (matched_reg
                           || sr_reg[6:0] == baud_reg[ssr_pkg::BAUD_MSB:0]);
    assign byte_done = full_byte
                       && (matched_reg
                           || sr_reg[6:0] == baud_reg[ssr_pkg::BAUD_MSB:0]);
    assign bf_set    = byte_done && !bf_reg;

    always_ff @(posedge mclk_i) begin
        if (reset_i || !en_reg || stop_seen) begin
            rx_reg      <= ssr_pkg::SSR_RX_IDLE;
            matched_reg <= 1'b0;
            ack_reg     <= 1'b0;
            bit_reg     <= 3'h0;
            sr_reg      <= 8'h00;
        end else if (start_seen) begin
            // a start inside the ack clock must not leave the ack armed
            rx_reg      <= ssr_pkg::SSR_RX_BITS;
            matched_reg <= 1'b0;
            ack_reg     <= 1'b0;
            bit_reg     <= 3'h0;
        end else begin
            unique case (rx_reg)
                ssr_pkg::SSR_RX_IDLE: rx_reg <= ssr_pkg::SSR_RX_IDLE;
                ssr_pkg::SSR_RX_BITS: if (scl_rise) begin
                    sr_reg  <= {sr_reg[6:0], ln_reg.sda};
                    bit_reg <= bit_reg + 3'h1;
                    if (bit_reg == ssr_pkg::BIT_LAST) begin
                        // address compared against the baud/address register
                        if (byte_done) begin
                            rx_reg      <= ssr_pkg::SSR_RX_ACK;
                            matched_reg <= 1'b1;
                            ack_reg     <= !bf_reg && !ov_reg;
                        end else
                            rx_reg <= ssr_pkg::SSR_RX_IDLE;
                    end
                end
                ssr_pkg::SSR_RX_ACK: if (scl_fall)
                    rx_reg <= ssr_pkg::SSR_RX_WAIT;
                ssr_pkg::SSR_RX_WAIT: if (scl_fall) begin
                    rx_reg  <= ssr_pkg::SSR_RX_BITS;
                    ack_reg <= 1'b0;
                end
            endcase
        end
    end

    // receive buffer loads from the shifter only when it was empty
    always_ff @(posedge mclk_i) begin
        if (reset_i)
            buf_reg <= 8'h00;
        else if (bf_set)
            buf_reg <= {sr_reg[6:0], ln_reg.sda};
    end
    // sda pulled low only across the ack clock: the sole slave drive
    assign rx_sda_low = ack_reg && rx_reg == ssr_pkg::SSR_RX_WAIT;

    ////////////////////////////////////////////////////////////////////
    // master start generator
    ssr_pkg::ssr_start_t st_reg;
    logic [6:0] brg_reg;
    logic       st_sda_low;
    logic       st_scl_low;
    assign bcol_evt = (st_reg == ssr_pkg::SSR_CHECK
                       && (!ln_reg.sda || !ln_reg.scl))
                      || (st_reg == ssr_pkg::SSR_HOLD1
                          && !ln_reg.scl && ln_reg.sda);

    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            st_reg     <= ssr_pkg::SSR_IDLE;
            brg_reg    <= 7'h00;
            st_sda_low <= 1'b0;
            st_scl_low <= 1'b0;
        end else begin
            unique case (st_reg)
                ssr_pkg::SSR_IDLE: if (go_start && en_reg) begin
                    st_reg     <= ssr_pkg::SSR_CHECK;  // lines released
                    st_sda_low <= 1'b0;
                    st_scl_low <= 1'b0;
                end
                // both lines watched on the check cycle and every cycle of the first count
                ssr_pkg::SSR_CHECK: if (bcol_evt)
                    st_reg  <= ssr_pkg::SSR_IDLE;
                else begin
                    st_reg  <= ssr_pkg::SSR_HOLD1;
                    brg_reg <= baud_reg[ssr_pkg::BAUD_MSB:0];
                end
                ssr_pkg::SSR_HOLD1: if (bcol_evt)
                    st_reg <= ssr_pkg::SSR_IDLE;
                else if (!ln_reg.sda || brg_reg == 7'h00) begin
                    // another master's early start is arbitrated later
                    st_sda_low <= 1'b1;
                    brg_reg    <= baud_reg[ssr_pkg::BAUD_MSB:0];
                    st_reg     <= ssr_pkg::SSR_HOLD2;
                end else
                    brg_reg <= brg_reg - 7'h01;
                // scl low here is ignored on purpose
                ssr_pkg::SSR_HOLD2: if (brg_reg == 7'h00) begin
                    st_scl_low <= 1'b1;
                    st_reg     <= ssr_pkg::SSR_DONE;
                end else
                    brg_reg <= brg_reg - 7'h01;
                ssr_pkg::SSR_DONE: if (go_start || !en_reg) begin
                    st_reg     <= ssr_pkg::SSR_IDLE;     // release for next use
                    st_sda_low <= 1'b0;
                    st_scl_low <= 1'b0;
                end
                default: st_reg <= ssr_pkg::SSR_IDLE;
            endcase
        end
    end

    // pad drivers: open drain, output value always low
    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            sda_oe_o <= 1'b0;
            scl_oe_o <= 1'b0;
            sda_o    <= 1'b0;
            scl_o    <= 1'b0;
        end else begin
            sda_oe_o <= st_sda_low | rx_sda_low;
            scl_oe_o <= st_scl_low;
            sda_o    <= 1'b0;
            scl_o    <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // assertions
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (reset_i);

    bcol_sets_flag_a: assert property (bcol_evt |=> ist_reg[1])
        else $error("collision flag not set");
    abort_goes_idle_a: assert property (
        st_reg == ssr_pkg::SSR_CHECK && !ln_reg.scl
        |=> st_reg == ssr_pkg::SSR_IDLE)
        else $error("start not aborted");
    no_ack_full_a: assert property (
        full_byte && bf_reg |=> !ack_reg)
        else $error("ack given while full");
    ovf_on_full_a: assert property (ov_set |=> ov_reg && ist_reg[0])
        else $error("overflow not flagged");
    buf_kept_a: assert property (
        bf_reg && !rd_buf |=> $stable(buf_reg))
        else $error("buffer overwritten");
    read_clears_bf_a: assert property (
        rd_buf && !bf_set |=> !bf_reg)
        else $error("buffer flag not cleared");
    load_baud_a: assert property (
        st_reg == ssr_pkg::SSR_CHECK && !bcol_evt
        |=> brg_reg == $past(baud_reg[ssr_pkg::BAUD_MSB:0]))
        else $error("counter not loaded");
    early_sda_a: assert property (
        st_reg == ssr_pkg::SSR_HOLD1 && !ln_reg.sda && ln_reg.scl
        |=> st_sda_low ##1 sda_oe_o)
        else $error("sda not driven early");
    second_ok_a: assert property (
        st_reg == ssr_pkg::SSR_HOLD2 && !ln_reg.scl
        |=> st_reg != ssr_pkg::SSR_IDLE && !bcol_evt)
        else $error("collision in second count");
    scl_after_a: assert property (
        st_reg == ssr_pkg::SSR_HOLD2 && brg_reg == 7'h00
        |=> st_scl_low ##1 scl_oe_o)
        else $error("scl not driven");
    cov_start_c: cover property (st_reg == ssr_pkg::SSR_DONE);
    cov_bcol_c: cover property (bcol_evt);
    cov_byte_c: cover property (bf_set);
    cov_ovf_c: cover property (ov_set);
endmodule : ssr_port

// ===== bench/ssr_bus_model.sv
// far-side bus party: a master that frames bytes and can hold lines low
`timescale 1ns/1ns
module ssr_bus_model (
    input  wire logic scl_i,
    input  wire logic sda_i,
    output logic      scl_pull_o,
    output logic      sda_pull_o
);
    localparam int HALF = 160; // half of the 320 ns link period

    // lines start released; the pull-ups make them idle high
    initial begin
        scl_pull_o = 1'b0;
        sda_pull_o = 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////
    // hold the lines at will, standing in for a competing master
    task automatic hold(input logic scl_lo, input logic sda_lo);
        #7;
        scl_pull_o = scl_lo;
        sda_pull_o = sda_lo;
    endtask : hold

    // start: sda falls while scl is high, then scl goes low
    task automatic start();
        #7;
        sda_pull_o = 1'b1;
        #(HALF);
        scl_pull_o = 1'b1;
    endtask : start

    // eight bits msb first, then sda released for the ack slot; the port
    // answers an scl edge about six clocks late, so the low phases around
    // the ack clock are stretched: otherwise its ack drive or release lands
    // while scl is high and reads as a start or stop
    task automatic send_byte(input logic [7:0] d, output logic ack);
        #7;
        for (int i = 7; i >= 0; i--) begin
            #(HALF / 2) sda_pull_o = ~d[i];
            #(HALF / 2) scl_pull_o = 1'b0;
            #(HALF) scl_pull_o = 1'b1;
        end
        #(HALF / 2) sda_pull_o = 1'b0;
        #(HALF * 3 / 2) scl_pull_o = 1'b0;
        #(HALF * 3 / 4) ack = ~sda_i;
        #(HALF / 4) scl_pull_o = 1'b1;
        #(HALF * 2);
    endtask : send_byte

    // stop: sda rises while scl is high
    task automatic stop();
        #7;
        sda_pull_o = 1'b1;
        #(HALF) scl_pull_o = 1'b0;
        #(HALF) sda_pull_o = 1'b0;
        #(HALF);
    endtask : stop
endmodule : ssr_bus_model

// ===== bench/ssr_port_test.sv
// self-checking bench for the two-wire port: slave receive and start
`timescale 1ns/1ns
module ssr_port_test;
    localparam logic [6:0] SLV = 7'h2a;
    logic       mclk_i;
    logic       reset_i;
    logic [3:0] addr_i;
    logic [7:0] wdata_i;
    logic       wr_i;
    logic       rd_i;
    logic [7:0] rdata_o;
    logic       irq_o;
    logic       scl_o;
    logic       scl_oe_o;
    logic       sda_o;
    logic       sda_oe_o;
    logic       scl_pull;
    logic       sda_pull;
    wire        scl_line;
    wire        sda_line;
    int         num_errors;
    int         checks;

    // open-drain lines with pull-ups: low while any party pulls
    assign scl_line = (scl_oe_o ? scl_o : 1'b1) & ~scl_pull;
    assign sda_line = (sda_oe_o ? sda_o : 1'b1) & ~sda_pull;

    ssr_port dut_u (.mclk_i(mclk_i), .reset_i(reset_i), .addr_i(addr_i),
        .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
        .irq_o(irq_o), .scl_i(scl_line), .sda_i(sda_line), .scl_o(scl_o),
        .scl_oe_o(scl_oe_o), .sda_o(sda_o), .sda_oe_o(sda_oe_o));
    ssr_bus_model m_u (.scl_i(scl_line), .sda_i(sda_line),
        .scl_pull_o(scl_pull), .sda_pull_o(sda_pull));

    // 25 MHz clock
    initial begin
        mclk_i = 1'b0;
        forever #20 mclk_i = ~mclk_i;
    end

    ////////////////////////////////////////////////////////////////////////
    task automatic give_verdict();
        $display("checks %0d errors %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : give_verdict

    task automatic chk(input string w, input logic [7:0] e,
                       input logic [7:0] g);
        checks++;
        if (g !== e) begin
            num_errors++;
            $display("unexpected %s: expected %h seen %h", w, e, g);
        end
    endtask : chk

    task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
        @(posedge mclk_i);
        addr_i  <= a;
        wdata_i <= d;
        wr_i    <= 1'b1;
        @(posedge mclk_i);
        wr_i    <= 1'b0;
    endtask : wr_reg

    // read data stand only in the cycle after the strobe
    task automatic rd_reg(input logic [3:0] a, output logic [7:0] d);
        @(posedge mclk_i);
        addr_i <= a;
        rd_i   <= 1'b1;
        @(posedge mclk_i);
        rd_i   <= 1'b0;
        #1;
        d = rdata_o;
    endtask : rd_reg

    task automatic rd_chk(input string w, input logic [3:0] a,
                          input logic [7:0] e);
        logic [7:0] d;
        rd_reg(a, d);
        chk(w, e, d);
    endtask : rd_chk

    // bounded wait for a line drive; running out ends the run
    task automatic wait_oe(input logic on_scl, input int lim, output int n);
        n = 0;
        while ((on_scl ? scl_oe_o : sda_oe_o) !== 1'b1) begin
            @(posedge mclk_i);
            #1;
            n++;
            if (n > lim) begin
                num_errors++;
                give_verdict();
            end
        end
    endtask : wait_oe

    task automatic settle(input int c);
        repeat (c) @(posedge mclk_i);
        #1;
    endtask : settle

    ////////////////////////////////////////////////////////////////////////
    task automatic t_reset();
        rd_chk("status", ssr_pkg::ADDR_STATUS, 8'h00);
        rd_chk("baud", ssr_pkg::ADDR_BAUD, ssr_pkg::BAUD_RST);
        rd_chk("irq st", ssr_pkg::ADDR_IRQST, {6'h0, ssr_pkg::IRQ_RST});
        wr_reg(4'hf, 8'hff);
        rd_chk("unmapped", 4'hf, 8'h00);
        chk("idle drive", 8'h00, {6'h0, sda_oe_o, scl_oe_o});
        chk("pad value", 8'h00, {6'h0, sda_o, scl_o});
    endtask : t_reset

    task automatic t_rx();
        logic       ack;
        logic [7:0] d;
        wr_reg(ssr_pkg::ADDR_CTRL, 8'h20);
        wr_reg(ssr_pkg::ADDR_BAUD, {1'b0, SLV ^ 7'h01});
        m_u.start();
        m_u.send_byte({SLV, 1'b0}, ack);
        chk("other addr", 8'h00, {7'h0, ack});
        m_u.stop();
        rd_chk("no store", ssr_pkg::ADDR_STATUS, 8'h00);
        wr_reg(ssr_pkg::ADDR_BAUD, {1'b0, SLV});
        wr_reg(ssr_pkg::ADDR_IRQMSK, 8'h01);
        m_u.start();
        m_u.send_byte({SLV, 1'b0}, ack);
        chk("addr ack", 8'h01, {7'h0, ack});
        rd_chk("full", ssr_pkg::ADDR_STATUS, 8'h01);
        chk("irq", 8'h01, {7'h0, irq_o});
        rd_chk("addr byte", ssr_pkg::ADDR_BUF, {SLV, 1'b0});
        rd_chk("empty", ssr_pkg::ADDR_STATUS, 8'h00);
        m_u.send_byte(8'h3c, ack);
        chk("data ack", 8'h01, {7'h0, ack});
        m_u.send_byte(8'h5a, ack);
        chk("full nack", 8'h00, {7'h0, ack});
        rd_chk("overflow", ssr_pkg::ADDR_CTRL, 8'h60);
        rd_chk("kept", ssr_pkg::ADDR_BUF, 8'h3c);
        m_u.send_byte(8'h11, ack);
        chk("ov nack", 8'h00, {7'h0, ack});
        wr_reg(ssr_pkg::ADDR_CTRL, 8'h20);
        rd_chk("ov clear", ssr_pkg::ADDR_CTRL, 8'h20);
        rd_reg(ssr_pkg::ADDR_BUF, d);
        m_u.send_byte(8'h22, ack);
        chk("ack again", 8'h01, {7'h0, ack});
        m_u.stop();
        rd_chk("last", ssr_pkg::ADDR_BUF, 8'h22);
        chk("released", 8'h00, {6'h0, sda_oe_o, scl_oe_o});
        wr_reg(ssr_pkg::ADDR_IRQMSK, 8'h00);
        settle(2);
        chk("masked", 8'h00, {7'h0, irq_o});
        wr_reg(ssr_pkg::ADDR_IRQST, 8'h01);
        rd_chk("irq clear", ssr_pkg::ADDR_IRQST, 8'h00);
    endtask : t_rx

    // clean start; a party pulling scl in the second count is no collision
    task automatic t_start();
        int n1;
        int n2;
        wr_reg(ssr_pkg::ADDR_BAUD, 8'h10);
        wr_reg(ssr_pkg::ADDR_CMD, 8'h01);
        wait_oe(1'b0, 100, n1);
        chk("first count", 8'h01, {7'h0, n1 >= 17 && n1 <= 21});
        m_u.hold(1'b1, 1'b0);
        wait_oe(1'b1, 100, n2);
        chk("second count", 8'h11, n2[7:0]);
        rd_chk("no bcol", ssr_pkg::ADDR_IRQST, 8'h00);
        m_u.hold(1'b0, 1'b0);
        wr_reg(ssr_pkg::ADDR_CTRL, 8'h00);
        wr_reg(ssr_pkg::ADDR_CTRL, 8'h20);
        settle(3);
        chk("start off", 8'h00, {6'h0, sda_oe_o, scl_oe_o});
    endtask : t_start

    task automatic t_bcol();
        int n;
        wr_reg(ssr_pkg::ADDR_IRQMSK, 8'h02);
        m_u.hold(1'b0, 1'b1);
        settle(6);
        wr_reg(ssr_pkg::ADDR_CMD, 8'h01);
        settle(30);
        chk("abort", 8'h00, {6'h0, sda_oe_o, scl_oe_o});
        chk("bcol irq", 8'h01, {7'h0, irq_o});
        m_u.hold(1'b0, 1'b0);
        settle(40);
        chk("no resume", 8'h00, {6'h0, sda_oe_o, scl_oe_o});
        rd_chk("sticky", ssr_pkg::ADDR_IRQST, 8'h02);
        wr_reg(ssr_pkg::ADDR_IRQST, 8'h02);
        rd_chk("bcol clear", ssr_pkg::ADDR_IRQST, 8'h00);
        // scl pulled while sda is still high, inside the first count
        wr_reg(ssr_pkg::ADDR_BAUD, 8'h40);
        wr_reg(ssr_pkg::ADDR_CMD, 8'h01);
        settle(8);
        m_u.hold(1'b1, 1'b0);
        settle(30);
        chk("scl abort", 8'h00, {6'h0, sda_oe_o, scl_oe_o});
        rd_chk("scl bcol", ssr_pkg::ADDR_IRQST, 8'h02);
        m_u.hold(1'b0, 1'b0);
        wr_reg(ssr_pkg::ADDR_IRQST, 8'h02);
        // sda pulled inside the first count: drive sda at once
        wr_reg(ssr_pkg::ADDR_CMD, 8'h01);
        settle(8);
        m_u.hold(1'b0, 1'b1);
        wait_oe(1'b0, 100, n);
        chk("early sda", 8'h01, {7'h0, n < 16});
        m_u.hold(1'b0, 1'b0);
        wait_oe(1'b1, 200, n);
        rd_chk("early ok", ssr_pkg::ADDR_IRQST, 8'h00);
        wr_reg(ssr_pkg::ADDR_CTRL, 8'h00);
    endtask : t_bcol

    ////////////////////////////////////////////////////////////////////////
    // main sequence: reset held for 12 cycles, then the scenarios
    initial begin
        reset_i    = 1'b1;
        addr_i     = 4'h0;
        wdata_i    = 8'h00;
        wr_i       = 1'b0;
        rd_i       = 1'b0;
        num_errors = 0;
        checks     = 0;
        repeat (12) @(posedge mclk_i);
        reset_i <= 1'b0;
        settle(6);
        t_reset();
        t_rx();
        t_start();
        t_bcol();
        give_verdict();
    end

    // cuts a hang short
    initial begin
        #2000000;
        num_errors++;
        give_verdict();
    end
endmodule : ssr_port_test
